// ==== src/hlim_cmd.sv ====
// Purpose: decoded command handler for harmonic limits and dc zeroing
// Assumes: the host text is parsed outside into host_cmd_t fields
// Notes: clearing a kind walks all 500 entries, one per cycle
`include "hlim_cfg.svh"
module hlim_cmd #(
   parameter int NUM_CH = `NUM_CH
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // command channel
   input wire logic cmd_valid_in,
   input wire hlim_pkg::host_cmd_t cmd_in,
   output logic cmd_ready_out,
   output logic cmd_error_out,
   // responses
   output logic resp_valid_out,
   output hlim_pkg::host_resp_t resp_out,
   // non-volatile commit request
   output logic commit_req_out,
   output logic commit_kind_out,
   // limit evaluation
   input wire logic eval_valid_in,
   input wire hlim_pkg::eval_req_t eval_in,
   output logic eval_done_out,
   output logic eval_pass_out,
   // channels
   input wire logic [NUM_CH-1:0] chan_configured_in,
   input wire logic [NUM_CH-1:0] chan_scaled_in,
   input wire logic [NUM_CH-1:0] chan_done_in,
   input wire logic [NUM_CH-1:0] chan_fail_in,
   input wire logic [NUM_CH*16-1:0] chan_dc_meas_in,
   output logic [NUM_CH-1:0] chan_zero_start_out,
   output logic [NUM_CH*16-1:0] chan_offset_out,
   // status
   output logic [NUM_CH-1:0] dc_zero_in_progress,
   output logic [NUM_CH-1:0] dc_zero_error_flags,
   output logic measure_suspend_out
);
   import hlim_pkg::*;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_clear = 2'b01,
      st_query = 2'b10
   } state_t;

   state_t state;
   state_t next_state;
   logic [8:0] clear_idx;
   logic clear_kind;
   host_cmd_t query_cmd;
   eval_req_t eval_s1;
   logic eval_v1;

   // field decode and checks
   wire logic take = cmd_valid_in & cmd_ready_out;
   wire logic [6:0] pres = cmd_in.present;
   wire logic order_ok = cmd_in.order >= `ORDER_MIN && cmd_in.order <= `ORDER_MAX;
   wire logic limits_given = pres[`F_REF] & pres[`F_PLIM] & pres[`F_LLIM];
   wire logic limits_pos = !cmd_in.plimit[16] && !cmd_in.llimit[16];
   wire logic no_limit = cmd_in.ltype == 2'h0;
   wire logic set_ok = pres[`F_KIND] & pres[`F_ORDER] & pres[`F_TYPE] & order_ok
      & (cmd_in.ltype <= `LTYPE_MAX)
      & (no_limit | (limits_given & limits_pos));
   wire logic opt_ok = pres[`F_OPT] && cmd_in.option <= `OPTION_MAX;

   logic cmd_ok;
   always_comb
   begin
      unique case (cmd_in.op)
         clear_harmonic_limits_cmd: cmd_ok = pres[`F_KIND];
         commit_harmonic_limits_cmd: cmd_ok = pres[`F_KIND];
         set_harmonic_limit_cmd: cmd_ok = set_ok;
         query_harmonic_limit_cmd: cmd_ok = pres[`F_KIND] & pres[`F_ORDER] & order_ok;
         external_zero_cmd: cmd_ok = opt_ok;
         internal_zero_start_cmd: cmd_ok = 1'b1;
         internal_zero_end_cmd: cmd_ok = 1'b1;
         query_zero_progress_cmd: cmd_ok = 1'b1;
         query_zero_error_cmd: cmd_ok = 1'b1;
         default: cmd_ok = 1'b0;
      endcase
   end

   wire logic good = take & cmd_ok;
   wire logic do_clear = good && cmd_in.op == clear_harmonic_limits_cmd;
   wire logic do_set = good && cmd_in.op == set_harmonic_limit_cmd;
   wire logic do_query = good && cmd_in.op == query_harmonic_limit_cmd;
   wire logic do_commit = good && cmd_in.op == commit_harmonic_limits_cmd;
   wire logic do_zstart = good && cmd_in.op == internal_zero_start_cmd;
   wire logic do_zend = good && cmd_in.op == internal_zero_end_cmd;
   wire logic do_extz = good && cmd_in.op == external_zero_cmd;
   wire logic do_zquery = good && (cmd_in.op == query_zero_progress_cmd
      || cmd_in.op == query_zero_error_cmd);

   // table write: a set or one step of a clear
   wire logic [8:0] order_idx = 9'(cmd_in.order - `ORDER_MIN);
   limit_entry_t set_entry;
   always_comb
   begin
      set_entry = '0;
      if (!no_limit)
      begin
         set_entry.ltype = cmd_in.ltype;
         set_entry.ref_total = cmd_in.ref_total;
         set_entry.plimit = cmd_in.plimit[15:0];
         set_entry.llimit = cmd_in.llimit[15:0];
      end
   end

   wire logic clearing = state == st_clear;
   wire logic wr_en = do_set | clearing;
   wire logic [9:0] wr_addr = clearing ? {clear_kind, clear_idx}
      : {cmd_in.kind_current, order_idx};
   wire limit_entry_t wr_data = clearing ? limit_entry_t'('0) : set_entry;
   wire logic [9:0] rd_a_addr = {cmd_in.kind_current, order_idx};
   wire logic [9:0] rd_b_addr = {eval_in.kind_current, 9'(eval_in.order - `ORDER_MIN)};
   limit_entry_t rd_a_data;
   limit_entry_t rd_b_data;

   limit_table_mem #(
      .WIDTH($bits(limit_entry_t)),
      .DEPTH(`TABLE_DEPTH),
      .AW(`TABLE_AW)
   ) u_table (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(wr_en),
      .wr_addr_in(wr_addr),
      .wr_data_in(wr_data),
      .rd_a_addr_in(rd_a_addr),
      .rd_a_data_out(rd_a_data),
      .rd_b_addr_in(rd_b_addr),
      .rd_b_data_out(rd_b_data)
   );

   // sequencing
   assign cmd_ready_out = state == st_idle; // busy while clearing or answering a limit query

   always_comb
   begin
      next_state = state;
      unique case (state)
         st_idle:
         begin
            if (do_clear)
            begin
               next_state = st_clear;
            end
            else if (do_query)
            begin
               next_state = st_query;
            end
         end
         st_clear:
         begin
            if (clear_idx == `ORDER_LAST_IDX)
            begin
               next_state = st_idle;
            end
         end
         st_query: next_state = st_idle;
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state <= st_idle;
         clear_idx <= 9'h000;
         clear_kind <= 1'b0;
         query_cmd <= '0;
      end
      else
      begin
         state <= next_state;
         clear_idx <= clearing ? clear_idx + 9'h001 : 9'h000;
         if (do_clear)
         begin
            clear_kind <= cmd_in.kind_current;
         end
         if (do_query)
         begin
            query_cmd <= cmd_in;
         end
      end
   end

   // responses, command error and commit pulses
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         resp_valid_out <= 1'b0;
         resp_out <= '0;
         cmd_error_out <= 1'b0;
         commit_req_out <= 1'b0;
         commit_kind_out <= 1'b0;
      end
      else
      begin
         cmd_error_out <= take & ~cmd_ok;
         commit_req_out <= do_commit;
         if (do_commit)
         begin
            commit_kind_out <= cmd_in.kind_current;
         end
         resp_valid_out <= do_zquery | (state == st_query);
         if (state == st_query)
         begin
            resp_out.op <= query_cmd.op;
            resp_out.kind_current <= query_cmd.kind_current;
            resp_out.order <= query_cmd.order;
            resp_out.entry <= rd_a_data;
            resp_out.word <= 4'h0;
         end
         else if (do_zquery)
         begin
            resp_out <= '0;
            resp_out.op <= cmd_in.op;
            resp_out.word <= (cmd_in.op == query_zero_progress_cmd) ?
               dc_zero_in_progress : dc_zero_error_flags;
         end
      end
   end

   // limit evaluation: read, then judge
   limit_entry_t ev;
   assign ev = rd_b_data;
   wire logic [15:0] ref_val = ev.ref_total ? eval_s1.total : eval_s1.fundamental;
   wire logic [31:0] pct_prod = 32'(ref_val) * 32'(ev.plimit);
   wire logic [32:0] pct_lim = 33'(pct_prod / `PCT_DIVISOR);
   wire logic [32:0] lvl_lim = 33'(ev.llimit);
   wire logic [32:0] max_lim = (pct_lim > lvl_lim) ? pct_lim : lvl_lim;
   wire logic [32:0] sum_lim = pct_lim + lvl_lim;
   wire logic [32:0] eff_lim = (ev.ltype == 2'h2) ? sum_lim : max_lim;
   wire logic both_zero = ev.plimit == 16'h0000 && ev.llimit == 16'h0000;
   wire logic judged = (ev.ltype == 2'h0) ? 1'b1
      : (!both_zero && 33'(eval_s1.harmonic) <= eff_lim);

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         eval_v1 <= 1'b0;
         eval_s1 <= '0;
         eval_done_out <= 1'b0;
         eval_pass_out <= 1'b0;
      end
      else
      begin
         eval_v1 <= eval_valid_in;
         eval_s1 <= eval_in;
         eval_done_out <= eval_v1;
         if (eval_v1)
         begin
            eval_pass_out <= judged;
         end
      end
   end

   // dc zeroing
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         measure_suspend_out <= 1'b0;
         chan_zero_start_out <= `ZERO_WORD_RESET;
      end
      else
      begin
         if (do_zstart)
         begin
            measure_suspend_out <= 1'b1;
         end
         else if (do_zend)
         begin
            measure_suspend_out <= 1'b0;
         end
         chan_zero_start_out <= do_zstart ? chan_configured_in : '0;
      end
   end

   wire logic [NUM_CH-1:0] ext_load = {NUM_CH{do_extz}}
      & ((cmd_in.option == 8'h00) ? {NUM_CH{1'b1}} : chan_scaled_in);

   for (genvar ch = 0; ch < NUM_CH; ch++)
   begin : g_ch
      zero_channel u_ch (
         .ref_clk_in(ref_clk_in),
         .rst_n_in(rst_n_in),
         .start_in(do_zstart),
         .end_in(do_zend),
         .ext_load_in(ext_load[ch]),
         .configured_in(chan_configured_in[ch]),
         .done_in(chan_done_in[ch]),
         .fail_in(chan_fail_in[ch]),
         .dc_meas_in(chan_dc_meas_in[ch*16 +: 16]),
         .busy_out(dc_zero_in_progress[ch]),
         .error_out(dc_zero_error_flags[ch]),
         .offset_out(chan_offset_out[ch*16 +: 16])
      );
   end
endmodule // hlim_cmd

// ==== src/hlim_cfg.svh ====
// Purpose: constants for the harmonic limit and dc zero command block
// Assumes: included by bare name from the command, channel, assertion and bench modules
// Notes: field positions index the presence mask of a command
`ifndef HLIM_CFG_SVH
`define HLIM_CFG_SVH

`define ORDER_MIN 10'h001
`define ORDER_MAX 10'h1f4
`define ORDER_LAST_IDX 9'h1f3
`define LTYPE_MAX 2'h2
`define OPTION_MAX 8'h01
`define PCT_DIVISOR 32'h0000_0064
`define NUM_CH 4
`define TABLE_DEPTH 1024
`define TABLE_AW 10
`define ZERO_WORD_RESET 4'h0

`define F_KIND 0
`define F_ORDER 1
`define F_TYPE 2
`define F_REF 3
`define F_PLIM 4
`define F_LLIM 5
`define F_OPT 6

`endif

// ==== src/hlim_pkg.sv ====
// Purpose: shared types for the harmonic limit and dc zero command block
// Assumes: hlim_cfg.svh holds the numbers
// Notes: limits are unsigned fixed point once stored
package hlim_pkg;

   typedef enum logic [3:0] {
      clear_harmonic_limits_cmd = 4'h0,
      set_harmonic_limit_cmd = 4'h1,
      query_harmonic_limit_cmd = 4'h2,
      commit_harmonic_limits_cmd = 4'h3,
      internal_zero_start_cmd = 4'h4,
      internal_zero_end_cmd = 4'h5,
      external_zero_cmd = 4'h6,
      query_zero_progress_cmd = 4'h7,
      query_zero_error_cmd = 4'h8
   } cmd_op_t;

   typedef struct packed {
      logic [1:0] ltype;
      logic ref_total;
      logic [15:0] plimit;
      logic [15:0] llimit;
   } limit_entry_t;

   typedef struct packed {
      cmd_op_t op;
      logic kind_current;
      logic [9:0] order;
      logic [1:0] ltype;
      logic ref_total;
      logic signed [16:0] plimit;
      logic signed [16:0] llimit;
      logic [7:0] option;
      logic [6:0] present;
   } host_cmd_t;

   typedef struct packed {
      cmd_op_t op;
      logic kind_current;
      logic [9:0] order;
      limit_entry_t entry;
      logic [3:0] word;
   } host_resp_t;

   typedef struct packed {
      logic kind_current;
      logic [9:0] order;
      logic [15:0] fundamental;
      logic [15:0] total;
      logic [15:0] harmonic;
   } eval_req_t;

endpackage

// ==== src/limit_table_mem.sv ====
// Purpose: harmonic limit table, one write port and two registered read ports
// Assumes: write and read of one address in one cycle returns the old word
// Notes: contents are volatile; no reset on the array
module limit_table_mem #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 1024,
   parameter int AW = 10
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // write port
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   // read ports
   input wire logic [AW-1:0] rd_a_addr_in,
   output logic [WIDTH-1:0] rd_a_data_out,
   input wire logic [AW-1:0] rd_b_addr_in,
   output logic [WIDTH-1:0] rd_b_data_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge ref_clk_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_a_data_out <= '0;
         rd_b_data_out <= '0;
      end
      else
      begin
         rd_a_data_out <= mem[rd_a_addr_in];
         rd_b_data_out <= mem[rd_b_addr_in];
      end
   end
endmodule // limit_table_mem

// ==== src/zero_channel.sv ====
// Purpose: one channel of internal and external dc zero state
// Assumes: start, end and load are one-cycle pulses from the command block
// Notes: an error reported in the start cycle survives the start's clear
`include "hlim_cfg.svh"
module zero_channel (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // command pulses
   input wire logic start_in,
   input wire logic end_in,
   input wire logic ext_load_in,
   // channel side
   input wire logic configured_in,
   input wire logic done_in,
   input wire logic fail_in,
   input wire logic [15:0] dc_meas_in,
   // state
   output logic busy_out,
   output logic error_out,
   output logic [15:0] offset_out
);
   wire logic start_here = start_in & configured_in;
   wire logic fail_seen = fail_in & (busy_out | start_here);

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         busy_out <= 1'b0;
      end
      else if (start_here)
      begin
         busy_out <= 1'b1;
      end
      else if (end_in || done_in)
      begin
         busy_out <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         error_out <= 1'b0;
      end
      else if (fail_seen && !end_in)
      begin
         error_out <= 1'b1;
      end
      else if (start_in || end_in)
      begin
         error_out <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         offset_out <= 16'h0000;
      end
      else if (ext_load_in)
      begin
         offset_out <= dc_meas_in;
      end
   end
endmodule // zero_channel

// ==== test/hlim_cmd_assertions.sv ====
// Purpose: concurrent checks on the command block ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound into every hlim_cmd instance below
`include "hlim_cfg.svh"
module hlim_cmd_assertions
   import hlim_pkg::*;
#(
   parameter int NUM_CH = 4
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // command side
   input wire logic cmd_valid_in,
   input wire hlim_pkg::host_cmd_t cmd_in,
   input wire logic cmd_ready_out,
   input wire logic cmd_error_out,
   input wire logic resp_valid_out,
   input wire logic commit_req_out,
   // channels and status
   input wire logic [NUM_CH-1:0] chan_configured_in,
   input wire logic [NUM_CH-1:0] chan_done_in,
   input wire logic [NUM_CH-1:0] chan_fail_in,
   input wire logic [NUM_CH-1:0] chan_zero_start_out,
   input wire logic [NUM_CH-1:0] dc_zero_in_progress,
   input wire logic [NUM_CH-1:0] dc_zero_error_flags,
   input wire logic measure_suspend_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic take = cmd_valid_in && cmd_ready_out;
   wire logic take_start = take && cmd_in.op == internal_zero_start_cmd;
   wire logic take_end = take && cmd_in.op == internal_zero_end_cmd;
   wire logic order_ok = cmd_in.order >= `ORDER_MIN && cmd_in.order <= `ORDER_MAX;
   wire logic take_query = take && cmd_in.op == query_harmonic_limit_cmd && order_ok
      && cmd_in.present[`F_KIND] && cmd_in.present[`F_ORDER];
   wire logic take_bad_set = take && cmd_in.op == set_harmonic_limit_cmd
      && (!order_ok || cmd_in.ltype > `LTYPE_MAX);

   start_pulse_a: assert property (take_start |=>
      chan_zero_start_out == $past(chan_configured_in) && measure_suspend_out)
      else $error("zero start not sent to configured channels");
   start_clear_a: assert property (take_start |=>
      (dc_zero_error_flags & ~$past(chan_fail_in)) == '0)
      else $error("error word kept over a zero start");
   end_clear_a: assert property (take_end |=>
      dc_zero_in_progress == '0 && dc_zero_error_flags == '0 && !measure_suspend_out)
      else $error("end of zeroing left state behind");
   progress_rise_a: assert property (
      (dc_zero_in_progress & ~$past(dc_zero_in_progress)) != '0 |-> $past(take_start))
      else $error("progress bit set without a start");
   progress_fall_a: assert property (
      (~dc_zero_in_progress & $past(dc_zero_in_progress) & ~$past(chan_done_in)) != '0
      |-> $past(take_end) || $past(take_start))
      else $error("progress bit dropped without done or end");
   error_rise_a: assert property (
      (dc_zero_error_flags & ~$past(dc_zero_error_flags) & ~$past(chan_fail_in)) == '0)
      else $error("error bit set without a channel fault");
   commit_req_a: assert property (
      take && cmd_in.op == commit_harmonic_limits_cmd && cmd_in.present[`F_KIND]
      |=> commit_req_out)
      else $error("commit not requested");
   query_resp_a: assert property (take_query |=> !cmd_ready_out ##1 resp_valid_out)
      else $error("limit query answer late or missing");
   bad_set_a: assert property (take_bad_set |=> cmd_error_out)
      else $error("out of range set not refused");
   clear_busy_a: assert property (
      take && cmd_in.op == clear_harmonic_limits_cmd && cmd_in.present[`F_KIND]
      |=> !cmd_ready_out [*8] ##[1:600] cmd_ready_out)
      else $error("clear walk length wrong");
endmodule // hlim_cmd_assertions

bind hlim_cmd hlim_cmd_assertions #(.NUM_CH(NUM_CH)) i_hlim_cmd_assertions (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
   .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .cmd_error_out(cmd_error_out),
   .resp_valid_out(resp_valid_out), .commit_req_out(commit_req_out),
   .chan_configured_in(chan_configured_in), .chan_done_in(chan_done_in),
   .chan_fail_in(chan_fail_in), .chan_zero_start_out(chan_zero_start_out),
   .dc_zero_in_progress(dc_zero_in_progress), .dc_zero_error_flags(dc_zero_error_flags),
   .measure_suspend_out(measure_suspend_out));

// ==== test/chan_model.sv ====
// Purpose: channel hardware stand-in answering zero start pulses
// Assumes: start pulses are one cycle wide per channel
// Notes: a channel in fail_mask_in reports a fault instead of done
module chan_model #(
   parameter int DLY = 5
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic [3:0] start_in,
   input wire logic [3:0] fail_mask_in,
   // answers
   output logic [3:0] done_out,
   output logic [3:0] fail_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [4];
   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      for (int i = 0; i < 4; i++)
      begin
         done_out[i] <= rst_n_in && cnt[i] == 1 && !fail_mask_in[i];
         fail_out[i] <= rst_n_in && cnt[i] == 1 && fail_mask_in[i];
         if (!rst_n_in)
            cnt[i] <= 0;
         else if (start_in[i])
            cnt[i] <= DLY;
         else if (cnt[i] > 0)
            cnt[i] <= cnt[i] - 1;
      end
   end
endmodule // chan_model

// ==== test/harmonic_limits_dc_zero_cmds_tb.sv ====
// Purpose: self-checking bench for the limit table and dc zero commands
// Assumes: tasks start just after a clock edge plus 1 ns
// Notes: channel 1 always faults during internal zeroing
`include "hlim_cfg.svh"
module harmonic_limits_dc_zero_cmds_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hlim_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   host_cmd_t cmd = '0;
   logic eval_valid = 1'b0;
   eval_req_t ev = '0;
   logic [3:0] cfg = 4'hb;
   logic [3:0] scaled = 4'h5;
   logic [3:0] fail_mask = 4'h2;
   logic [63:0] meas = 64'h4444_3333_2222_1111;
   logic cmd_ready, cmd_error, resp_valid, commit_req, commit_kind, eval_done, eval_pass;
   logic suspend;
   host_resp_t resp;
   logic [3:0] done, fail, zstart, dzip, dzerr;
   logic [63:0] offs;
   int miscompares = 0;
   int n_checks = 0;
   localparam logic [34:0] ENT500 = {2'h1, 1'b1, 16'h000a, 16'h00c8};

   hlim_cmd i_hlim_cmd (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .cmd_valid_in(cmd_valid),
      .cmd_in(cmd), .cmd_ready_out(cmd_ready), .cmd_error_out(cmd_error),
      .resp_valid_out(resp_valid), .resp_out(resp), .commit_req_out(commit_req),
      .commit_kind_out(commit_kind), .eval_valid_in(eval_valid), .eval_in(ev),
      .eval_done_out(eval_done), .eval_pass_out(eval_pass), .chan_configured_in(cfg),
      .chan_scaled_in(scaled), .chan_done_in(done), .chan_fail_in(fail),
      .chan_dc_meas_in(meas), .chan_zero_start_out(zstart), .chan_offset_out(offs),
      .dc_zero_in_progress(dzip), .dc_zero_error_flags(dzerr),
      .measure_suspend_out(suspend));
   chan_model i_chan_model (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .start_in(zstart),
      .fail_mask_in(fail_mask), .done_out(done), .fail_out(fail));

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic end_sim();
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   function automatic host_cmd_t mk(input cmd_op_t op, input logic k, input logic [9:0] h,
      input logic [1:0] t, input logic r, input logic [15:0] p, input logic [15:0] l,
      input logic [7:0] o);
      host_cmd_t c;
      c = '{op, k, h, t, r, {1'b0, p}, {1'b0, l}, o, 7'h7f};
      return c;
   endfunction

   // returns 1 ns after the take edge, while one-cycle answers still stand
   task automatic send(input host_cmd_t c);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd <= c;
      cmd_valid <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (cmd_ready !== 1'b1 && n < 1000);
      cmd_valid <= 1'b0;
      if (cmd_ready !== 1'b1)
      begin
         miscompares++;
      end
      #1;
   endtask

   task automatic set_lim(input logic k, input logic [9:0] h, input logic [1:0] t,
      input logic r, input logic [15:0] p, input logic [15:0] l);
      send(mk(set_harmonic_limit_cmd, k, h, t, r, p, l, 8'h00));
   endtask

   task automatic qchk(input logic k, input logic [9:0] h, input logic [34:0] exp);
      send(mk(query_harmonic_limit_cmd, k, h, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      @(posedge ref_clk);
      #1;
      chk(resp_valid, 1'b1);
      chk(resp.entry, exp);
      chk({resp.kind_current, resp.order}, {k, h});
   endtask

   task automatic evchk(input logic [15:0] t, input logic [15:0] h, input logic exp);
      @(posedge ref_clk);
      eval_valid <= 1'b1;
      ev <= '{1'b0, 10'h002, 16'h03e8, t, h};
      @(posedge ref_clk);
      eval_valid <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(eval_done, 1'b1);
      chk(eval_pass, exp);
   endtask

   task automatic t_table();
      set_lim(1'b0, 10'h1f4, 2'h1, 1'b1, 16'h000a, 16'h00c8); // host keeps order
      qchk(1'b0, 10'h1f4, ENT500);
      set_lim(1'b1, 10'h001, 2'h0, 1'b1, 16'h0007, 16'h0009);
      qchk(1'b1, 10'h001, 35'h0);
   endtask

   task automatic t_eval();
      set_lim(1'b0, 10'h002, 2'h1, 1'b0, 16'h000a, 16'h0032);
      evchk(16'h0000, 16'h0064, 1'b1);
      evchk(16'h0000, 16'h0065, 1'b0);
      set_lim(1'b0, 10'h002, 2'h2, 1'b0, 16'h000a, 16'h0032);
      evchk(16'h0000, 16'h0096, 1'b1);
      evchk(16'h0000, 16'h0097, 1'b0);
      set_lim(1'b0, 10'h002, 2'h1, 1'b1, 16'h000a, 16'h0032);
      evchk(16'h07d0, 16'h00c8, 1'b1);
      evchk(16'h07d0, 16'h00c9, 1'b0);
      set_lim(1'b0, 10'h002, 2'h1, 1'b0, 16'h0000, 16'h0000); // non-negative
      evchk(16'h0000, 16'h0000, 1'b0);
      set_lim(1'b0, 10'h002, 2'h0, 1'b0, 16'h0000, 16'h0000);
      evchk(16'h0000, 16'hea60, 1'b1);
   endtask

   task automatic t_refuse();
      host_cmd_t c;
      for (int i = 0; i < 5; i++)
      begin
         c = mk(set_harmonic_limit_cmd, 1'b0, 10'h1f4, 2'h2, 1'b0, 16'h1, 16'h1, 8'h00);
         case (i)
            0: c.order = 10'h000;
            1: c.order = 10'h1f5;
            2: c.ltype = 2'h3;
            3: c.plimit = 17'h1ffff;
            default: c.present[`F_LLIM] = 1'b0;
         endcase
         send(c);
         chk(cmd_error, 1'b1);
      end
      qchk(1'b0, 10'h1f4, ENT500);
   endtask

   task automatic t_clear();
      set_lim(1'b1, 10'h007, 2'h2, 1'b0, 16'h0003, 16'h0004);
      send(mk(clear_harmonic_limits_cmd, 1'b1, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      qchk(1'b1, 10'h007, 35'h0);
      qchk(1'b0, 10'h1f4, ENT500);
      send(mk(commit_harmonic_limits_cmd, 1'b1, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk(commit_req, 1'b1);
      chk(commit_kind, 1'b1);
   endtask

   task automatic t_zero();
      send(mk(internal_zero_start_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk(zstart, 4'hb);
      chk(dzip, 4'hb);
      chk(dzerr, 4'h0);
      chk(suspend, 1'b1);
      repeat (8) @(posedge ref_clk);
      #1;
      chk(dzip, 4'h2);
      chk(dzerr, 4'h2);
      send(mk(query_zero_progress_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk(resp.word, 4'h2);
      send(mk(query_zero_error_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk(resp.word, 4'h2);
      send(mk(internal_zero_start_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk(dzerr, 4'h0);
      send(mk(internal_zero_end_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk({dzip, dzerr}, 8'h00);
      chk(suspend, 1'b0);
   endtask

   task automatic t_ext();
      send(mk(external_zero_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h01));
      chk(offs, 64'h0000_3333_0000_1111);
      send(mk(external_zero_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h02));
      chk(cmd_error, 1'b1);
      send(mk(external_zero_cmd, 1'b0, 10'h0, 2'h0, 1'b0, 16'h0, 16'h0, 8'h00));
      chk(offs, 64'h4444_3333_2222_1111);
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_table();
      t_eval();
      t_refuse();
      t_clear();
      t_zero();
      t_ext();
      end_sim();
   end

   // the clear walk dominates; the whole run needs well under 5000 cycles
   initial
   begin
      #50000;
      miscompares++;
      end_sim();
   end
endmodule // harmonic_limits_dc_zero_cmds_tb
